/* rtl/operand_volt.sv */
// offset-corrected, expanded output voltage of one measured quantity
`timescale 1ns/100ps
module operand_volt import scaler_pkg::*; (
  // request and answer
  opv_if.conv p
);
  logic signed [24:0] diff;
  logic signed [47:0] prod;
  logic signed [47:0] mv;

  always_comb begin
    diff = p.sub ? ({p.val[23], p.val} - {p.off[23], p.off}) : {p.val[23], p.val};
    prod = diff * $signed({1'b0, p.expand}) * 48'(FULL_MV);
    mv   = prod >>> FS_FRAC;
    // clip to the output span; a large expand just pins the output
    if (mv > 48'(FULL_MV)) begin
      p.volt = FULL_MV;
    end else if (mv < -48'(FULL_MV)) begin
      p.volt = -FULL_MV;
    end else begin
      p.volt = mv[15:0];
    end
    p.corr = diff[23:0];
  end
endmodule : operand_volt

/* rtl/opv_if.sv */
// operand voltage conversion link between the scaler and its converters
`timescale 1ns/100ps
interface opv_if;
  logic signed [23:0] val;
  logic signed [23:0] off;
  logic [8:0]         expand;
  logic               sub;
  logic signed [23:0] corr;
  logic signed [15:0] volt;
  modport user (output val, output off, output expand, output sub, input corr, input volt);
  modport conv (input val, input off, input expand, input sub, output corr, output volt);
endinterface : opv_if

/* rtl/output_offset_expand_scaler.sv */
// offset/expand scaler: rear and front outputs, trace voltage and trace value
//
// Functional notes
// RL1 - offsets are fractions of full scale, clamped to +-105 percent
// RL2 - corrected value is multiplied by an integer expand of 1 to 256
// RL3 - X/Y/R output is (norm - offset) * expand * 10 V, limited to 10 V
// RL4 - R uses its own offset and expand, never those of X or Y
// RL5 - displayed X/Y/R trace operands have their offset subtracted
// RL6 - offset indicator when the trace uses a quantity with non-zero offset
// RL7 - displayed trace values are not scaled by expand
// RL8 - expand indicator when the trace uses a quantity with expand not one; code flags X, Y, R only, not noise using their expand
// RL9 - trace values are in the quantity's own units, offset included
// RL10 - each operand first becomes a voltage bounded to +-10 V
// RL11 - product traces divide the operand voltage product by 10
// RL12 - trace voltages include the X/Y/R offset
// RL13 - trace voltages include the X/Y/R expand factor
// RL14 - phase maps to 10 V per 180 degrees
// RL15 - frequency maps 5 V to 10 V across each octave, then wraps
// RL16 - octave edges are powers of two times 62.5 Hz
// RL17 - R, phase and trace results refresh at 512 Hz
// RL18 - a trace is A times B divided by C over selectable operands
// RL19 - phase stays within -180 to +180 degrees whatever the sensitivity
// RL20 - trace voltage saturates to +-10 V; zero divisor gives a defined result
`timescale 1ns/100ps
module output_offset_expand_scaler import scaler_pkg::*; #(
  parameter int TICK_CYCLES = UPDATE_CYCLES
) (
  // clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RSTN,
  // register port
  input  wire logic [7:0]         ADDR,
  input  wire logic [31:0]        WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output      logic [31:0]        RDATA,
  // detector results, normalised to full scale
  input  wire logic signed [23:0] X_NORM,
  input  wire logic signed [23:0] Y_NORM,
  input  wire logic signed [23:0] R_NORM,
  input  wire logic signed [23:0] IN_PHASE_NOISE_VALUE,
  input  wire logic signed [23:0] QUADRATURE_NOISE_VALUE,
  input  wire logic signed [23:0] MAGNITUDE_NOISE_VALUE,
  // other operands
  input  wire logic signed [31:0] PHASE_DEG,
  input  wire logic [31:0]        FREQ,
  input  wire logic [63:0]        AUX_IN,
  input  wire logic signed [31:0] SENS,
  // outputs in millivolts
  output      logic signed [15:0] X_OUT,
  output      logic signed [15:0] Y_OUT,
  output      logic signed [15:0] FRONT_OUTPUT_CHANNEL_ONE,
  output      logic signed [15:0] FRONT_OUTPUT_CHANNEL_TWO,
  output      logic signed [15:0] TRACE_VOLT,
  // display side
  output      logic signed [31:0] TRACE_VALUE,
  output      logic               OFFSET_IND,
  output      logic               EXPAND_IND,
  output      logic               UPDATE_STROBE
);
  typedef struct packed {
    logic [32:0] rem;
    logic [63:0] quo;
    logic [31:0] dvs;
    logic        neg;
    logic        nz;
    logic [6:0]  cnt;
  } div_t;

  typedef struct packed {
    logic [2:0][23:0] off;
    logic [2:0][8:0]  expd;
    opsel_t           sa;
    opsel_t           sb;
    opsel_t           sc;
    chsel_t           c1;
    chsel_t           c2;
    logic [31:0]      tick;
    fsm_t             fsm;
    div_t             dv;
    logic [63:0]      numd;
    logic [31:0]      dend;
    logic [15:0]      xo;
    logic [15:0]      yo;
    logic [15:0]      fo1;
    logic [15:0]      fo2;
    logic [15:0]      rv;
    logic [15:0]      pv;
    logic [15:0]      tv;
    logic [31:0]      td;
    logic             oind;
    logic             eind;
    logic             upd;
    logic [31:0]      rdata;
  } state_t;

  localparam state_t STATE_RST = '{expd: {3{EXPAND_RST}}, sa: OP_X, sb: OP_UNITY,
                                   sc: OP_UNITY, c1: CH_X, c2: CH_Y, fsm: ST_IDLE,
                                   default: '0};

  state_t             s_reg;
  state_t             s_next;
  opv_if              opv[6] ();
  logic signed [23:0] norm[6];
  logic signed [15:0] cv[6];
  logic signed [23:0] cc[6];
  opsel_t             sel[3];
  logic signed [15:0] vol[3];
  logic signed [31:0] dsp[3];
  logic               uni[3];
  logic signed [47:0] ph_prod;
  logic signed [15:0] ph_mv;
  logic signed [15:0] fq_mv;
  logic [31:0]        fq_m;
  logic [4:0]         fq_msb;
  logic signed [63:0] num_v;
  logic signed [31:0] den_v;
  logic signed [63:0] num_d;
  logic signed [31:0] den_d;
  logic               offs_hit;
  logic               expd_hit;
  logic               tick_hit;

  assign norm = '{X_NORM, Y_NORM, R_NORM, IN_PHASE_NOISE_VALUE, QUADRATURE_NOISE_VALUE,
                  MAGNITUDE_NOISE_VALUE};
  assign sel  = '{s_reg.sa, s_reg.sb, s_reg.sc};

  // X, Y, R keep their own offset/expand; noise uses expand only
  for (genvar i = 0; i < 6; i++) begin : g_conv
    assign opv[i].val    = norm[i];
    assign opv[i].off    = (i < 3) ? s_reg.off[i % 3] : 24'h000000; // RL4 RL12
    assign opv[i].expand = s_reg.expd[i % 3]; // RL13
    assign opv[i].sub    = (i < 3);
    assign cv[i]         = opv[i].volt;
    assign cc[i]         = opv[i].corr;
    operand_volt u_conv (.p(opv[i]));
  end

  function automatic logic signed [15:0] sat_mv(input logic signed [63:0] v);
    if (v > 64'(FULL_MV)) begin
      return FULL_MV;
    end else if (v < -64'(FULL_MV)) begin
      return -FULL_MV;
    end
    return v[15:0];
  endfunction : sat_mv

  function automatic logic [23:0] clamp_off(input logic signed [23:0] v);
    if (v > OFFSET_LIMIT) begin
      return OFFSET_LIMIT; // RL1
    end else if (v < -OFFSET_LIMIT) begin
      return -OFFSET_LIMIT; // RL1
    end
    return v;
  endfunction : clamp_off

  function automatic logic [8:0] clamp_exp(input logic [15:0] v);
    if (v < 16'(EXPAND_MIN)) begin
      return EXPAND_MIN; // RL2
    end else if (v > 16'(EXPAND_MAX)) begin
      return EXPAND_MAX; // RL2
    end
    return v[8:0];
  endfunction : clamp_exp

  // magnitudes go through a restoring divider, the sign is kept aside
  function automatic div_t div_load(input logic signed [63:0] num,
                                    input logic signed [31:0] den);
    div_t d;
    d     = '0;
    d.quo = num[63] ? 64'(-num) : 64'(num);
    d.dvs = den[31] ? 32'(-den) : 32'(den);
    d.neg = num[63] ^ den[31];
    d.nz  = (num != 64'sh0);
    return d;
  endfunction : div_load

  function automatic logic [15:0] chan_mv(input chsel_t c);
    case (c)
      CH_X:     return cv[0];
      CH_Y:     return cv[1];
      CH_R:     return s_reg.rv;
      CH_PHASE: return s_reg.pv;
      CH_TRACE: return s_reg.tv;
      default:  return 16'h0000;
    endcase
  endfunction : chan_mv

  // phase and frequency voltages
  always_comb begin
    ph_prod = PHASE_DEG * PHASE_K;
    ph_mv   = sat_mv(64'(ph_prod >>> PHASE_SHIFT)); // RL14 RL19
    fq_msb  = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (FREQ[i]) begin
        fq_msb = 5'(i);
      end
    end
    // octave edges fall on powers of two of the 62.5/1024 Hz input LSB
    fq_m  = FREQ << (5'h1f - fq_msb); // RL16
    fq_mv = 16'(FREQ_BASE_MV + ((32'(fq_m[30:31-FREQ_FRAC]) * FREQ_SPAN_MV) >> FREQ_FRAC)); // RL15
  end

  // operand voltages, display values and indicators
  always_comb begin
    int idx;
    logic signed [63:0] dprod;
    idx      = 0;
    dprod    = 64'sh0;
    offs_hit = 1'b0;
    expd_hit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      uni[k] = 1'b0;
      idx    = (sel[k] <= OP_R) ? int'(sel[k]) : int'(sel[k]) - 1;
      case (sel[k])
        OP_X, OP_Y, OP_R, OP_XNOISE, OP_YNOISE, OP_RNOISE: begin
          vol[k] = cv[idx]; // RL10
          // corrected value, scaled by sensitivity, not by expand
          dprod  = cc[idx] * SENS; // RL5 RL7 RL9
          dsp[k] = 32'(dprod >>> FS_FRAC);
        end
        OP_PH: begin
          vol[k] = ph_mv;
          dsp[k] = PHASE_DEG >>> (16 - DISP_FRAC);
        end
        OP_FRQ: begin
          vol[k] = fq_mv;
          dsp[k] = 32'(($signed({1'b0, FREQ}) * FREQ_DISP_K) >>> FREQ_DISP_SH);
        end
        OP_AUX1, OP_AUX2, OP_AUX3, OP_AUX4: begin
          vol[k] = sat_mv(64'($signed(AUX_IN[(int'(sel[k]) - 8) * 16 +: 16]))); // RL10
          dprod  = $signed(AUX_IN[(int'(sel[k]) - 8) * 16 +: 16]) * AUX_DISP_K;
          dsp[k] = 32'(dprod >>> AUX_DISP_SH);
        end
        default: begin
          vol[k] = UNITY_MV;
          dsp[k] = UNITY_DISP;
          uni[k] = 1'b1;
        end
      endcase
      if (sel[k] <= OP_R) begin
        offs_hit = offs_hit | (s_reg.off[idx] != 24'h000000); // RL6
        expd_hit = expd_hit | (s_reg.expd[idx] != EXPAND_RST); // RL8
      end
    end
    // unity numerator factors count as one volt
    num_v = 64'(uni[0] ? UNITY_MV : vol[0]) * 64'(uni[1] ? UNITY_MV : vol[1]); // RL18
    if (uni[2]) begin
      den_v = (!uni[0] && !uni[1]) ? PRODUCT_DEN : SINGLE_DEN; // RL11
    end else begin
      den_v = 32'(vol[2]);
    end
    num_d = 64'(dsp[0]) * 64'(dsp[1]); // RL9
    den_d = dsp[2];
  end

  // registers, bus, divider sequence
  always_comb begin
    logic [32:0] tmp;
    logic        qb;
    logic [63:0] q;
    logic [15:0] mag;
    // a zero divisor leaves an all-ones quotient, which then saturates
    tmp = {s_reg.dv.rem[31:0], s_reg.dv.quo[63]};
    qb  = (tmp >= {1'b0, s_reg.dv.dvs});
    if (qb) begin
      tmp = tmp - {1'b0, s_reg.dv.dvs};
    end
    q            = {s_reg.dv.quo[62:0], qb};
    mag          = 16'h0000;
    s_next       = s_reg;
    s_next.rdata = 32'h00000000;
    s_next.upd   = 1'b0;
    if (WR) begin
      for (int i = 0; i < 3; i++) begin
        if (ADDR == REG_XOFF + 8'(REG_STRIDE * i)) begin
          s_next.off[i] = clamp_off(WDATA[23:0]); // RL1
        end
        if (ADDR == REG_XEXP + 8'(REG_STRIDE * i)) begin
          s_next.expd[i] = clamp_exp(WDATA[15:0]); // RL2
        end
      end
      if (ADDR == REG_TSEL) begin
        s_next.sa = opsel_t'(WDATA[TSEL_A_LSB +: 4]);
        s_next.sb = opsel_t'(WDATA[TSEL_B_LSB +: 4]);
        s_next.sc = opsel_t'(WDATA[TSEL_C_LSB +: 4]);
        s_next.c1 = chsel_t'(WDATA[TSEL_C1_LSB +: 3]);
        s_next.c2 = chsel_t'(WDATA[TSEL_C2_LSB +: 3]);
      end
    end
    if (RD) begin
      for (int i = 0; i < 3; i++) begin
        if (ADDR == REG_XOFF + 8'(REG_STRIDE * i)) begin
          s_next.rdata = {{8{s_reg.off[i][23]}}, s_reg.off[i]};
        end
        if (ADDR == REG_XEXP + 8'(REG_STRIDE * i)) begin
          s_next.rdata = {23'h000000, s_reg.expd[i]};
        end
      end
      case (ADDR)
        REG_TSEL:  s_next.rdata = {13'h0000, s_reg.c2, 1'b0, s_reg.c1, s_reg.sc, s_reg.sb,
                                   s_reg.sa};
        REG_STAT:  s_next.rdata = {29'h00000000, s_reg.fsm != ST_IDLE, s_reg.eind, s_reg.oind};
        REG_TVOLT: s_next.rdata = {{16{s_reg.tv[15]}}, s_reg.tv};
        REG_TVAL:  s_next.rdata = s_reg.td;
        default:   ;
      endcase
    end
    s_next.xo   = cv[0]; // RL3
    s_next.yo   = cv[1];
    s_next.fo1  = chan_mv(s_reg.c1);
    s_next.fo2  = chan_mv(s_reg.c2);
    s_next.oind = offs_hit; // RL6
    s_next.eind = expd_hit; // RL8
    tick_hit    = (s_reg.tick >= 32'(TICK_CYCLES - 1));
    s_next.tick = tick_hit ? 32'h00000000 : s_reg.tick + 32'h00000001; // RL17
    case (s_reg.fsm)
      ST_IDLE: begin
        if (tick_hit) begin
          s_next.rv   = cv[2]; // RL17
          s_next.pv   = ph_mv;
          s_next.numd = num_d;
          s_next.dend = den_d;
          s_next.dv   = div_load(num_v, den_v); // RL18
          s_next.fsm  = ST_VOLT;
        end
      end
      ST_VOLT, ST_DISP: begin
        s_next.dv.rem = tmp;
        s_next.dv.quo = q;
        s_next.dv.cnt = s_reg.dv.cnt + 7'h01;
        if (s_reg.dv.cnt == DIV_LAST) begin
          if (s_reg.fsm == ST_VOLT) begin
            mag = (q > 64'(FULL_MV)) ? FULL_MV : q[15:0]; // RL20
            s_next.tv  = !s_reg.dv.nz ? 16'h0000 : (s_reg.dv.neg ? -mag : mag); // RL20
            s_next.dv  = div_load(s_reg.numd, s_reg.dend);
            s_next.fsm = ST_DISP;
          end else begin
            q          = (q > 64'h000000007fffffff) ? 64'h000000007fffffff : q;
            s_next.td  = !s_reg.dv.nz ? 32'h00000000 :
                         (s_reg.dv.neg ? -q[31:0] : q[31:0]); // RL9
            s_next.fsm = ST_IDLE;
            s_next.upd = 1'b1;
          end
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA                    = s_reg.rdata;
  assign X_OUT                    = s_reg.xo;
  assign Y_OUT                    = s_reg.yo;
  assign FRONT_OUTPUT_CHANNEL_ONE = s_reg.fo1;
  assign FRONT_OUTPUT_CHANNEL_TWO = s_reg.fo2;
  assign TRACE_VOLT               = s_reg.tv;
  assign TRACE_VALUE              = s_reg.td;
  assign OFFSET_IND               = s_reg.oind;
  assign EXPAND_IND               = s_reg.eind;
  assign UPDATE_STROBE            = s_reg.upd;

  offset_range_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL1
    WR && ADDR == REG_XOFF |=> $signed(s_reg.off[0]) <= OFFSET_LIMIT &&
                               $signed(s_reg.off[0]) >= -OFFSET_LIMIT)
    else $error("x offset beyond 105 percent");
  expand_range_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL2
    WR && ADDR == REG_XEXP && WDATA[15:0] == 16'h0000 |=> s_reg.expd[0] == EXPAND_MIN)
    else $error("expand of zero not raised to one");
  rear_out_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL3
    ##1 X_OUT == $past(cv[0]) && X_OUT <= FULL_MV && X_OUT >= -FULL_MV)
    else $error("rear x output wrong or above 10 V");
  offset_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL6
    s_reg.sa == OP_X && s_reg.off[0] != 24'h000000 |=> OFFSET_IND)
    else $error("offset indicator missing");
  expand_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL8
    s_reg.sa == OP_X && s_reg.expd[0] != EXPAND_RST |=> EXPAND_IND)
    else $error("expand indicator missing");
  phase_chan_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL14
    s_reg.c1 == CH_PHASE |=> FRONT_OUTPUT_CHANNEL_ONE == $past(s_reg.pv))
    else $error("channel one not showing phase voltage");
  update_seq_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL17
    s_reg.fsm == ST_IDLE && tick_hit |=> s_reg.fsm == ST_VOLT ##64 s_reg.fsm == ST_DISP
    ##64 UPDATE_STROBE)
    else $error("trace update sequence broken");
  trace_sat_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN) // RL20
    $changed(TRACE_VOLT) |-> TRACE_VOLT <= FULL_MV && TRACE_VOLT >= -FULL_MV)
    else $error("trace voltage beyond 10 V");
endmodule : output_offset_expand_scaler

/* rtl/scaler_pkg.sv */
// constants and types shared by the offset/expand output scaler
package scaler_pkg;
  // normalised measurement: signal/sensitivity, full scale = 2**FS_FRAC
  localparam int                 FS_FRAC      = 20;
  localparam logic signed [23:0] OFFSET_LIMIT = 24'sh10cccc;   // 1.05 of full scale
  localparam logic [8:0]         EXPAND_MIN   = 9'h001;
  localparam logic [8:0]         EXPAND_MAX   = 9'h100;
  localparam logic [8:0]         EXPAND_RST   = 9'h001;
  // voltages in millivolts
  localparam logic signed [15:0] FULL_MV      = 16'sh2710;     // 10 V
  localparam logic signed [15:0] UNITY_MV     = 16'sh03e8;     // 1 V, neutral factor
  localparam logic signed [31:0] PRODUCT_DEN  = 32'sh00002710; // product traces divide by 10
  localparam logic signed [31:0] SINGLE_DEN   = 32'sh000003e8;
  localparam logic [31:0]        FREQ_BASE_MV = 32'h00001388;  // 5 V at octave start
  localparam logic [31:0]        FREQ_SPAN_MV = 32'h00001388;  // 5 V across one octave
  localparam int                 FREQ_FRAC    = 14;
  // phase input in degrees, 16 fraction bits; 10 V per 180 degrees
  // rounded, not truncated, so that 90 degrees lands on 5 V exactly
  localparam logic signed [17:0] PHASE_K      = 18'((10000 * 1024 + 90) / 180);
  localparam int                 PHASE_SHIFT  = 26;
  // display values carry DISP_FRAC fraction bits
  localparam int                 DISP_FRAC    = 8;
  localparam logic signed [31:0] UNITY_DISP   = 32'sh00000100;
  localparam logic signed [17:0] AUX_DISP_K   = 18'((256 * 1024) / 1000);
  localparam int                 AUX_DISP_SH  = 10;
  localparam logic signed [17:0] FREQ_DISP_K  = 18'sh0007d;    // freq LSB is 62.5/1024 Hz
  localparam int                 FREQ_DISP_SH = 3;
  // trace update rate
  localparam int                 CLK_HZ        = 125000000;
  localparam int                 UPDATE_HZ     = 512;
  localparam int                 UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam logic [6:0]         DIV_LAST      = 7'h3f;
  // register map
  localparam logic [7:0] REG_XOFF   = 8'h00;
  localparam logic [7:0] REG_XEXP   = 8'h0c;
  localparam int         REG_STRIDE = 4;
  localparam logic [7:0] REG_TSEL   = 8'h18;
  localparam logic [7:0] REG_STAT   = 8'h1c;
  localparam logic [7:0] REG_TVOLT  = 8'h20;
  localparam logic [7:0] REG_TVAL   = 8'h24;
  localparam int TSEL_A_LSB  = 0;
  localparam int TSEL_B_LSB  = 4;
  localparam int TSEL_C_LSB  = 8;
  localparam int TSEL_C1_LSB = 12;
  localparam int TSEL_C2_LSB = 16;
  localparam int STAT_OFFS   = 0;
  localparam int STAT_EXPD   = 1;
  localparam int STAT_BUSY   = 2;

  typedef enum logic [3:0] {
    OP_X = 4'h0, OP_Y = 4'h1, OP_R = 4'h2, OP_PH = 4'h3,
    OP_XNOISE = 4'h4, OP_YNOISE = 4'h5, OP_RNOISE = 4'h6, OP_FRQ = 4'h7,
    OP_AUX1 = 4'h8, OP_AUX2 = 4'h9, OP_AUX3 = 4'ha, OP_AUX4 = 4'hb, OP_UNITY = 4'hc
  } opsel_t;
  typedef enum logic [2:0] {
    CH_X = 3'h0, CH_Y = 3'h1, CH_R = 3'h2, CH_PHASE = 3'h3, CH_TRACE = 3'h4
  } chsel_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_VOLT = 2'h1, ST_DISP = 2'h2} fsm_t;
endpackage : scaler_pkg

/* test/testbench.sv */
// self-checking bench for the offset/expand output scaler
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import scaler_pkg::*;;
  localparam int TICK = 200;
  logic                CORE_CLK  = 1'b0;
  logic                RSTN      = 1'b0;
  logic [7:0]          ADDR      = 8'h00;
  logic [31:0]         WDATA     = 32'h0;
  logic                WR        = 1'b0;
  logic                RD        = 1'b0;
  logic [31:0]         RDATA;
  logic signed [23:0]  X_NORM    = 24'sh0;
  logic signed [23:0]  Y_NORM    = 24'sh0;
  logic signed [23:0]  R_NORM    = 24'sh0;
  logic signed [23:0]  NZ        = 24'sh0;
  logic signed [31:0]  PHASE_DEG = 32'sh0;
  logic [31:0]         FREQ      = 32'h0;
  logic [63:0]         AUX_IN    = 64'h0;
  logic signed [31:0]  SENS      = 32'sh100;
  logic signed [15:0]  X_OUT, Y_OUT, OUT_ONE, OUT_TWO, TRACE_VOLT;
  logic signed [31:0]  TRACE_VALUE;
  logic                OFFSET_IND, EXPAND_IND, UPDATE_STROBE;
  int                  miscompares = 0;
  int                  n_checks    = 0;

  output_offset_expand_scaler #(.TICK_CYCLES(TICK)) uut (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .X_NORM(X_NORM), .Y_NORM(Y_NORM), .R_NORM(R_NORM),
    .IN_PHASE_NOISE_VALUE(NZ), .QUADRATURE_NOISE_VALUE(NZ), .MAGNITUDE_NOISE_VALUE(NZ),
    .PHASE_DEG(PHASE_DEG), .FREQ(FREQ), .AUX_IN(AUX_IN), .SENS(SENS), .X_OUT(X_OUT),
    .Y_OUT(Y_OUT), .FRONT_OUTPUT_CHANNEL_ONE(OUT_ONE), .FRONT_OUTPUT_CHANNEL_TWO(OUT_TWO),
    .TRACE_VOLT(TRACE_VOLT), .TRACE_VALUE(TRACE_VALUE), .OFFSET_IND(OFFSET_IND),
    .EXPAND_IND(EXPAND_IND), .UPDATE_STROBE(UPDATE_STROBE));

  initial begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    `CHK(RDATA, e)
  endtask : rd_chk

  task automatic cfg(input int q, input logic [31:0] off, input logic [31:0] ex);
    wr(8'(REG_XOFF + q * REG_STRIDE), off);
    wr(8'(REG_XEXP + q * REG_STRIDE), ex);
  endtask : cfg

  task automatic tsel(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c,
                      input logic [2:0] c1, input logic [2:0] c2);
    wr(REG_TSEL, {13'h0, c2, 1'b0, c1, c, b, a});
  endtask : tsel

  // two updates, so the second one cannot carry stale operands
  task automatic wait_upd;
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge CORE_CLK);
        #1;
        k++;
      end while (UPDATE_STROBE !== 1'b1 && k < 3 * TICK);
      `CHK(UPDATE_STROBE, 1'b1)
    end
  endtask : wait_upd

  task automatic test_regs;
    for (int q = 0; q < 3; q++) begin
      rd_chk(8'(REG_XOFF + q * REG_STRIDE), 32'h0);
      rd_chk(8'(REG_XEXP + q * REG_STRIDE), 32'h1);
    end
    rd_chk(REG_TSEL, 32'h00010cc0);
    wr(8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h0);
    wr(REG_XOFF, 32'h00200000);
    rd_chk(REG_XOFF, 32'h0010cccc);
    @(posedge CORE_CLK);
    #1;
    `CHK(RDATA, 32'h0)
    wr(REG_XOFF, 32'h00e00000);
    rd_chk(REG_XOFF, 32'hffef3334);
    wr(REG_XEXP, 32'h0);
    rd_chk(REG_XEXP, 32'h1);
    wr(REG_XEXP, 32'h300);
    rd_chk(REG_XEXP, 32'h100);
    $display("test regs done");
  endtask : test_regs

  task automatic test_xout;
    cfg(0, 32'h00080000, 32'h2);
    cfg(1, 32'h00080000, 32'h1);
    X_NORM <= 24'sh0c0000;
    Y_NORM <= 24'sh040000;
    repeat (3) @(posedge CORE_CLK);
    #1;
    `CHK(X_OUT, 16'sd5000)
    `CHK(Y_OUT, -16'sd2500)
    cfg(0, 32'h00080000, 32'h100);
    Y_NORM <= -24'sh100000;
    repeat (3) @(posedge CORE_CLK);
    #1;
    `CHK(X_OUT, 16'sd10000)
    `CHK(Y_OUT, -16'sd10000)
    $display("test xout done");
  endtask : test_xout

  task automatic test_trace_x;
    int k;
    cfg(1, 32'h0, 32'h1);
    cfg(2, 32'h0, 32'h1);
    cfg(0, 32'h00080000, 32'h2);
    tsel(OP_X, OP_UNITY, OP_UNITY, CH_R, CH_TRACE);
    R_NORM <= 24'sh080000;
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd5000)
    `CHK(TRACE_VALUE, 32'sd64)
    `CHK(OFFSET_IND, 1'b1)
    `CHK(EXPAND_IND, 1'b1)
    k = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      k++;
    end while (UPDATE_STROBE !== 1'b1 && k < 3 * TICK);
    `CHK(k, TICK)
    `CHK(OUT_TWO, 16'sd5000)
    `CHK(OUT_ONE, 16'sd5000)
    rd_chk(REG_STAT, 32'h3);
    cfg(0, 32'h0, 32'h1);
    X_NORM <= 24'sh040000;
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd2500)
    `CHK(TRACE_VALUE, 32'sd64)
    `CHK(OFFSET_IND, 1'b0)
    `CHK(EXPAND_IND, 1'b0)
    $display("test trace_x done");
  endtask : test_trace_x

  task automatic test_product;
    tsel(OP_X, OP_Y, OP_UNITY, CH_X, CH_TRACE);
    X_NORM <= 24'sh100000;
    Y_NORM <= 24'sh080000;
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd5000)
    `CHK(TRACE_VALUE, 32'sd128)
    tsel(OP_X, OP_Y, OP_R, CH_X, CH_TRACE);
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd10000)
    `CHK(TRACE_VALUE, 32'sd256)
    R_NORM <= 24'sh0;
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd10000)
    `CHK(TRACE_VALUE, 32'sh7fffffff)
    // operand clipped to 10 V before the product, so 5 V and not 15 V
    cfg(0, 32'h0, 32'h4);
    X_NORM <= 24'sh0c0000;
    tsel(OP_X, OP_Y, OP_UNITY, CH_X, CH_TRACE);
    wait_upd();
    `CHK(TRACE_VOLT, 16'sd5000)
    $display("test product done");
  endtask : test_product

  task automatic test_phase;
    int                 dg [2] = '{90, -180};
    logic signed [15:0] ev [2] = '{16'sd5000, -16'sd10000};
    tsel(OP_PH, OP_UNITY, OP_UNITY, CH_PHASE, CH_TRACE);
    for (int i = 0; i < 2; i++) begin
      PHASE_DEG <= 32'(dg[i] * 65536);
      wait_upd();
      `CHK(TRACE_VOLT, ev[i])
      `CHK(TRACE_VALUE, 32'(dg[i] * 256))
      @(posedge CORE_CLK);
      #1;
      `CHK(OUT_ONE, ev[i])
    end
    $display("test phase done");
  endtask : test_phase

  task automatic test_freq;
    logic [31:0]        fv [5] = '{32'h4000, 32'h6000, 32'h8000, 32'h1000, 32'h1800};
    logic signed [15:0] ev [5] = '{16'sd5000, 16'sd7500, 16'sd5000, 16'sd5000, 16'sd7500};
    tsel(OP_FRQ, OP_UNITY, OP_UNITY, CH_X, CH_TRACE);
    for (int i = 0; i < 5; i++) begin
      FREQ <= fv[i];
      wait_upd();
      `CHK(TRACE_VOLT, ev[i])
      `CHK(TRACE_VALUE, 32'((fv[i] * 125) >> 3))
    end
    $display("test freq done");
  endtask : test_freq

  // noise takes the X expand but no offset; aux enters as volts
  task automatic test_noise_aux;
    cfg(0, 32'h00080000, 32'h2);
    NZ     <= 24'sh040000;
    AUX_IN <= 64'h000000000000fc18;
    tsel(OP_XNOISE, OP_AUX1, OP_UNITY, CH_Y, CH_TRACE);
    wait_upd();
    `CHK(TRACE_VOLT, -16'sd500)
    `CHK(TRACE_VALUE, -32'sd64)
    `CHK(OUT_ONE, 16'sd5000)
    $display("test noise_aux done");
  endtask : test_noise_aux

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // roughly thirty updates of work; a hang stops well beyond that
  initial begin
    #(TICK * 100 * 8);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge CORE_CLK);
    `CHK({X_OUT, Y_OUT, TRACE_VOLT}, 48'h0)
    RSTN <= 1'b1;
    test_regs();
    test_xout();
    test_trace_x();
    test_product();
    test_phase();
    test_freq();
    test_noise_aux();
    finish_test();
  end
endmodule : testbench
